// File: rtl/rlg_delay.sv
// on/off delay primitive counted in whole logic cycles
`timescale 1ns/1ps
`default_nettype none
module rlg_delay
  import rlg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // evaluation strobe and data
  input wire logic tick,
  input wire logic din,
  // delay settings in ms
  input wire logic [DLY_MS_W-1:0] rise_ms,
  input wire logic [DLY_MS_W-1:0] fall_ms,
  // delayed output
  output logic dout_q
);
  logic [DLY_MS_W:0] elapsed_q;
  logic [DLY_MS_W:0] elapsed_d;
  logic out_d;

  // pick the setting for the pending direction
  wire logic [DLY_MS_W:0] target = {1'b0, din ? rise_ms : fall_ms};
  wire logic pending = din != dout_q;
  wire logic expired = elapsed_q >= target;
  wire logic [DLY_MS_W:0] step_sum = elapsed_q + (DLY_MS_W+1)'(LOGIC_CYCLE_MS);

  // elapsed time restarts whenever the input agrees with the output again
  always_comb begin
    elapsed_d = elapsed_q;
    out_d = dout_q;
    if (tick) begin
      if (!pending) begin
        elapsed_d = '0;
      end else if (expired) begin
        out_d = din;
        elapsed_d = '0;
      end else begin
        elapsed_d = step_sum;
      end
    end
  end

  // state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_q <= '0;
      dout_q <= 1'b0;
    end else begin
      elapsed_q <= elapsed_d;
      dout_q <= out_d;
    end
  end

  // output only moves on a tick, toward an input already seen for the full delay
  chk_dly_move: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(dout_q) |-> $past(tick) && ($past(din) == dout_q) && ($past(elapsed_q) >= $past(target)))
    else $error("delay output moved before its delay ran out");
  chk_dly_restart: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !pending |=> elapsed_q == '0)
    else $error("delay timer not restarted");
endmodule
`default_nettype wire

// File: rtl/rlg_logic_engine.sv
// relay logic engine: gate library evaluated every logic cycle, configured over apb
`timescale 1ns/1ps
`default_nettype none
module rlg_logic_engine
  import rlg_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
)(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // relay binary signals and front panel back key
  input wire logic [NUM_SIG-1:0] sig_in,
  input wire logic back_key,
  // measurement from same-clock logic
  input wire logic [MEAS_W-1:0] meas_in,
  // primitive results and cycle strobe
  output logic [RES_W-1:0] logic_out,
  output logic cycle_done
);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CNT - 1);

  // configuration registers
  logic run_q;
  logic [NUM_GATE_IN-1:0] and_mask_q;
  logic [NUM_GATE_IN-1:0] or_mask_q;
  logic [NUM_GATE_IN-1:0] xor_mask_q;
  logic [NUM_GATE_IN-1:0] nor_mask_q;
  logic [3:0] not_sel_q;
  logic [31:0] latch_sel_q;
  logic [31:0] seq_sel_q;
  logic [23:0] edge_sel_q;
  logic [CNT_W-1:0] cnt_trig_q;
  logic [CMP_CFG_W-1:0] cmp_cfg_q;
  logic [DLY_CFG_W-1:0] dly_cfg_q [NUM_DLY];
  // input conditioning and cycle timing
  logic [NUM_SIG:0] sync1_q;
  logic [NUM_SIG:0] sync2_q;
  logic [NUM_SIG:0] sync3_q;
  logic [NUM_SIG:0] pin_q;
  logic back_pend_q;
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic tick_q;
  // primitive state
  logic [31:0] prev_node_q;
  logic [4:0] gate_q;
  logic sr_q;
  logic rs_q;
  logic dff_q;
  logic [CNT_W-1:0] cnt_q;
  logic cnt_out_q;
  logic edge_q;
  logic panel_q;
  logic cmp_q;
  logic g_cmp;
  logic [NUM_DLY-1:0] dly_out;
  logic [31:0] rd_mux;

  // apb decode
  wire logic apb_setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready & pwrite;
  wire logic dly_hit = paddr[7:6] == REG_DLY_PAGE;
  wire logic [3:0] dly_idx = paddr[5:2];
  wire logic addr_ok = (paddr[1:0] == 2'h0) & (dly_hit | (paddr <= REG_CAPACITY));
  wire logic wr_ok = wr_en & addr_ok;
  wire logic we_ctrl = wr_ok & (paddr == REG_CTRL);
  wire logic we_and = wr_ok & (paddr == REG_AND_MASK);
  wire logic we_or = wr_ok & (paddr == REG_OR_MASK);
  wire logic we_xor = wr_ok & (paddr == REG_XOR_MASK);
  wire logic we_nor = wr_ok & (paddr == REG_NOR_MASK);
  wire logic we_not = wr_ok & (paddr == REG_NOT_SEL);
  wire logic we_latch = wr_ok & (paddr == REG_LATCH_SEL);
  wire logic we_seq = wr_ok & (paddr == REG_SEQ_SEL);
  wire logic we_edge = wr_ok & (paddr == REG_EDGE_SEL);
  wire logic we_trig = wr_ok & (paddr == REG_CNT_TRIG);
  wire logic we_cmp = wr_ok & (paddr == REG_CMP_CFG);
  wire logic we_dly = wr_ok & dly_hit;

  // apb answer: one wait-free access phase after each setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= apb_setup & ~addr_ok;
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= CTRL_RUN_RST;
      and_mask_q <= '0;
      or_mask_q <= '0;
      xor_mask_q <= '0;
      nor_mask_q <= '0;
      not_sel_q <= '0;
      latch_sel_q <= '0;
      seq_sel_q <= '0;
      edge_sel_q <= '0;
      cnt_trig_q <= CNT_TRIG_RST;
      cmp_cfg_q <= '0;
    end else begin
      if (we_ctrl) run_q <= pwdata[0];
      if (we_and) and_mask_q <= pwdata[NUM_GATE_IN-1:0];
      if (we_or) or_mask_q <= pwdata[NUM_GATE_IN-1:0];
      if (we_xor) xor_mask_q <= pwdata[NUM_GATE_IN-1:0];
      if (we_nor) nor_mask_q <= pwdata[NUM_GATE_IN-1:0];
      if (we_not) not_sel_q <= pwdata[3:0];
      if (we_latch) latch_sel_q <= pwdata;
      if (we_seq) seq_sel_q <= pwdata;
      if (we_edge) edge_sel_q <= pwdata[23:0];
      if (we_trig) cnt_trig_q <= pwdata[CNT_W-1:0];
      if (we_cmp) cmp_cfg_q <= pwdata[CMP_CFG_W-1:0];
    end
  end

  // delay settings, one word per delay primitive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_DLY; i++) dly_cfg_q[i] <= '0;
    end else if (we_dly) begin
      dly_cfg_q[dly_idx] <= pwdata[DLY_CFG_W-1:0];
    end
  end

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dly_hit) begin
      rd_mux = {3'h0, dly_cfg_q[dly_idx]};
    end else begin
      case (paddr)
        REG_CTRL: rd_mux = {31'h0000_0000, run_q};
        REG_AND_MASK: rd_mux = {22'h00_0000, and_mask_q};
        REG_OR_MASK: rd_mux = {22'h00_0000, or_mask_q};
        REG_XOR_MASK: rd_mux = {22'h00_0000, xor_mask_q};
        REG_NOR_MASK: rd_mux = {22'h00_0000, nor_mask_q};
        REG_NOT_SEL: rd_mux = {28'h000_0000, not_sel_q};
        REG_LATCH_SEL: rd_mux = latch_sel_q;
        REG_SEQ_SEL: rd_mux = seq_sel_q;
        REG_EDGE_SEL: rd_mux = {8'h00, edge_sel_q};
        REG_CNT_TRIG: rd_mux = {16'h0000, cnt_trig_q};
        REG_CMP_CFG: rd_mux = {13'h0000, cmp_cfg_q};
        REG_CNT_VAL: rd_mux = {16'h0000, cnt_q};
        REG_RESULT: rd_mux = {4'h0, logic_out};
        REG_CAPACITY: rd_mux = {MAX_WIRES, MAX_GATES};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // pin synchroniser: a bit changes once the second and third stage agree
  wire logic [NUM_SIG:0] agree = ~(sync2_q ^ sync3_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_q <= '0;
    end else begin
      sync1_q <= {back_key, sig_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (pin_q & ~agree) | (sync3_q & agree);
    end
  end

  // back key press is held until the next cycle consumes it; a new press wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) back_pend_q <= 1'b0;
    else back_pend_q <= pin_q[NUM_SIG] | (back_pend_q & ~tick_q);
  end

  // logic cycle strobe, one pulse every cycle period while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (!run_q) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
      tick_q <= tick_cnt_q == TICK_LAST;
    end
  end

  // first stage: stateless gates and comparator
  wire logic [NUM_SIG-1:0] sig = pin_q[NUM_SIG-1:0];
  wire logic [NUM_GATE_IN-1:0] gin = sig[NUM_GATE_IN-1:0];
  wire logic g_not = ~sig[not_sel_q];
  wire logic g_and = (|and_mask_q) & (&(gin | ~and_mask_q));
  wire logic g_or = |(gin & or_mask_q);
  wire logic g_xor = $countones(gin & xor_mask_q) == 1;
  wire logic g_nor = ~|(gin & nor_mask_q);
  wire logic [MEAS_W-1:0] cmp_val = cmp_cfg_q[CMP_VAL_LSB +: MEAS_W];
  wire logic [2:0] cmp_op = cmp_cfg_q[CMP_OP_LSB +: 3];

  // comparator relation
  always_comb begin
    case (cmp_op)
      CMP_EQ: g_cmp = meas_in == cmp_val;
      CMP_NE: g_cmp = meas_in != cmp_val;
      CMP_LT: g_cmp = meas_in < cmp_val;
      CMP_GT: g_cmp = meas_in > cmp_val;
      CMP_LE: g_cmp = meas_in <= cmp_val;
      CMP_GE: g_cmp = meas_in >= cmp_val;
      default: g_cmp = 1'b0;
    endcase
  end

  // node vector: first-stage results feed the second stage in the same cycle
  wire logic [31:0] node = {10'h000, g_cmp, g_nor, g_xor, g_or, g_and, g_not, sig};

  // second stage input selection
  wire logic sr_set = node[latch_sel_q[SEL_F0 +: NODE_W]];
  wire logic sr_clr = node[latch_sel_q[SEL_F1 +: NODE_W]];
  wire logic rs_set = node[latch_sel_q[SEL_F2 +: NODE_W]];
  wire logic rs_clr = node[latch_sel_q[SEL_F3 +: NODE_W]];
  wire logic [NODE_W-1:0] dff_d_idx = seq_sel_q[SEL_F0 +: NODE_W];
  wire logic [NODE_W-1:0] dff_c_idx = seq_sel_q[SEL_F1 +: NODE_W];
  wire logic [NODE_W-1:0] cnt_idx = seq_sel_q[SEL_F2 +: NODE_W];
  wire logic cnt_clr = node[seq_sel_q[SEL_F3 +: NODE_W]];
  wire logic [NODE_W-1:0] edge_idx = edge_sel_q[SEL_F0 +: NODE_W];
  wire logic edge_pol = node[edge_sel_q[SEL_F1 +: NODE_W]];
  wire logic panel_in = node[edge_sel_q[SEL_F2 +: NODE_W]];

  // transitions are judged against the value seen at the previous cycle
  wire logic dff_rise = node[dff_c_idx] & ~prev_node_q[dff_c_idx];
  wire logic count_pulse_input = node[cnt_idx] & ~prev_node_q[cnt_idx];
  wire logic edge_up = node[edge_idx] & ~prev_node_q[edge_idx];
  wire logic edge_dn = ~node[edge_idx] & prev_node_q[edge_idx];

  // second stage next values
  wire logic sr_d = sr_set | (~sr_clr & sr_q);
  wire logic rs_d = ~rs_clr & (rs_set | rs_q);
  wire logic dff_d = dff_rise ? node[dff_d_idx] : dff_q;
  wire logic cnt_full = cnt_q == {CNT_W{1'b1}};
  wire logic [CNT_W-1:0] cnt_inc = (count_pulse_input & ~cnt_full) ? cnt_q + 1'b1 : cnt_q;
  wire logic [CNT_W-1:0] cnt_d = cnt_clr ? '0 : cnt_inc;
  wire logic edge_d = edge_pol ? edge_up : edge_dn;
  wire logic panel_d = panel_in | (~back_pend_q & panel_q);

  // evaluation of all primitives, once per logic cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_node_q <= '0;
      gate_q <= '0;
      sr_q <= 1'b0;
      rs_q <= 1'b0;
      dff_q <= 1'b0;
      cnt_q <= '0;
      cnt_out_q <= 1'b0;
      edge_q <= 1'b0;
      panel_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (tick_q) begin
      prev_node_q <= node;
      gate_q <= {g_nor, g_xor, g_or, g_and, g_not};
      sr_q <= sr_d;
      rs_q <= rs_d;
      dff_q <= dff_d;
      cnt_q <= cnt_d;
      cnt_out_q <= cnt_d >= cnt_trig_q;
      edge_q <= edge_d;
      panel_q <= panel_d;
      cmp_q <= g_cmp;
    end
  end

  // sixteen delay primitives, each with its own input select and settings
  for (genvar i = 0; i < NUM_DLY; i++) begin : g_dly
    rlg_delay u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_q),
      .din(node[dly_cfg_q[i][DLY_SEL_LSB +: NODE_W]]),
      .rise_ms(dly_cfg_q[i][DLY_RISE_LSB +: DLY_MS_W]),
      .fall_ms(dly_cfg_q[i][DLY_FALL_LSB +: DLY_MS_W]),
      .dout_q(dly_out[i])
    );
  end

  // outputs straight from state flops
  assign logic_out = {dly_out, cmp_q, panel_q, edge_q, cnt_out_q, dff_q, rs_q, sr_q, gate_q};
  assign cycle_done = tick_q;

  // checks
  sequence s_edge_seen;
    tick_q && edge_d;
  endsequence
  sequence s_edge_quiet;
    tick_q && !edge_d;
  endsequence

  chk_not_out: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> gate_q[RES_NOT] == ~$past(sig[not_sel_q]))
    else $error("inverter output not complement of input");
  chk_and_out: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && (|and_mask_q) && ((gin & and_mask_q) == and_mask_q) |=> gate_q[RES_AND])
    else $error("conjunction low with all inputs high");
  chk_or_out: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> gate_q[RES_OR] == (|$past(gin & or_mask_q)))
    else $error("disjunction output wrong");
  chk_xor_two: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && ($countones(gin & xor_mask_q) > 1) |=> !gate_q[RES_XOR])
    else $error("exclusive-or high with several inputs high");
  chk_nor_out: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && (|(gin & nor_mask_q)) |=> !gate_q[RES_NOR])
    else $error("not-or high with an input high");
  chk_sr_both: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && sr_set && sr_clr |=> sr_q)
    else $error("set-dominant latch not set with both inputs");
  chk_rs_both: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && rs_set && rs_clr |=> !rs_q)
    else $error("reset-dominant latch not clear with both inputs");
  chk_panel_win: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q && panel_in && back_pend_q |=> panel_q)
    else $error("panel latch cleared against its input");
  chk_cnt_sat: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_full && !(tick_q && cnt_clr) |=> cnt_full)
    else $error("counter left its maximum without clear");
  chk_cnt_trig: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> cnt_out_q == (cnt_q >= $past(cnt_trig_q)))
    else $error("counter output disagrees with trigger");
  chk_edge_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_edge_seen ##1 edge_q ##[1:32] s_edge_quiet |=> !edge_q)
    else $error("edge pulse outlived one cycle");
  chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |-> $past(tick_cnt_q) == TICK_LAST)
    else $error("logic cycle strobe off period");
endmodule
`default_nettype wire

// File: rtl/rlg_pkg.sv
// package: register map, field layout, reset values and timing of the relay logic engine
// Contract
// - inverter output is the complement of its single input every evaluation
// - conjunction output high only when every connected input is high
// - disjunction output high when any connected input is high
// - exclusive-or output high when exactly one connected input is high
// - not-or output high only while no connected input is high
// - set-dominant latch sets, holds, clears; both inputs high gives 1
// - reset-dominant latch like set-dominant, but both inputs high gives 0
// - flip-flop samples data on rising clock input, otherwise holds
// - counter adds one each time its count input goes high; the code holds the count once it reaches its all-ones maximum
// - counter output high while count is at least the trigger value
// - counter clear input returns the count to zero
// - delay holds separate millisecond rise and fall settings
// - at most sixteen delay primitives in one configuration
// - edge primitive gives one 5 ms pulse on selected transition, else low
// - polarity high selects rising transitions, low selects falling
// - panel latch sets on input, back key clears, input wins over clear
// - comparator output high while measurement satisfies operator against value
// - operator selects equal, not equal, less, greater, less-equal, greater-equal
// - all primitives evaluated once per logic cycle of 5 ms
// - evaluation runs left to right, upstream results feed downstream same cycle
// - multi-input gates accept up to ten inputs
// - configuration limited to 768 primitives and 256 wires
package rlg_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOGIC_CYCLE_MS = 5;
  localparam int TICK_CYCLES = LOGIC_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 20;
  // sizes
  localparam int NUM_SIG = 16;
  localparam int NUM_GATE_IN = 10;
  localparam int NUM_DLY = 16;
  localparam int NODE_W = 5;
  localparam int DLY_MS_W = 12;
  localparam int CNT_W = 16;
  localparam int MEAS_W = 16;
  localparam int RES_W = 12 + NUM_DLY;
  localparam logic [15:0] MAX_GATES = 16'h0300;
  localparam logic [15:0] MAX_WIRES = 16'h0100;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AND_MASK = 8'h04;
  localparam logic [7:0] REG_OR_MASK = 8'h08;
  localparam logic [7:0] REG_XOR_MASK = 8'h0C;
  localparam logic [7:0] REG_NOR_MASK = 8'h10;
  localparam logic [7:0] REG_NOT_SEL = 8'h14;
  localparam logic [7:0] REG_LATCH_SEL = 8'h18;
  localparam logic [7:0] REG_SEQ_SEL = 8'h1C;
  localparam logic [7:0] REG_EDGE_SEL = 8'h20;
  localparam logic [7:0] REG_CNT_TRIG = 8'h24;
  localparam logic [7:0] REG_CMP_CFG = 8'h28;
  localparam logic [7:0] REG_CNT_VAL = 8'h2C;
  localparam logic [7:0] REG_RESULT = 8'h30;
  localparam logic [7:0] REG_CAPACITY = 8'h34;
  localparam logic [1:0] REG_DLY_PAGE = 2'h1;
  // field positions
  localparam int SEL_F0 = 0;
  localparam int SEL_F1 = 8;
  localparam int SEL_F2 = 16;
  localparam int SEL_F3 = 24;
  localparam int DLY_RISE_LSB = 0;
  localparam int DLY_FALL_LSB = 12;
  localparam int DLY_SEL_LSB = 24;
  localparam int DLY_CFG_W = 29;
  localparam int CMP_VAL_LSB = 0;
  localparam int CMP_OP_LSB = 16;
  localparam int CMP_CFG_W = 19;
  // reset values
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [CNT_W-1:0] CNT_TRIG_RST = 16'h0001;
  // node indices: 0..15 are binary signals
  localparam int NODE_NOT = 16;
  localparam int NODE_AND = 17;
  localparam int NODE_OR = 18;
  localparam int NODE_XOR = 19;
  localparam int NODE_NOR = 20;
  localparam int NODE_CMP = 21;
  // result bit positions
  localparam int RES_NOT = 0;
  localparam int RES_AND = 1;
  localparam int RES_OR = 2;
  localparam int RES_XOR = 3;
  localparam int RES_NOR = 4;
  localparam int RES_DLY = 12;
  // comparator operators
  typedef enum logic [2:0] {
    CMP_EQ = 3'h0,
    CMP_NE = 3'h1,
    CMP_LT = 3'h2,
    CMP_GT = 3'h3,
    CMP_LE = 3'h4,
    CMP_GE = 3'h5
  } rlg_cmp_op_t;
endpackage

// File: tb/rlg_relay_side.sv
// relay-side model: binary signals, back key and measurement feeding the engine
`timescale 1ns/1ps
`default_nettype none
module rlg_relay_side
  import rlg_pkg::*;
(
  // clock
  input wire logic pclk,
  // commands from the bench
  input wire logic [NUM_SIG-1:0] sig_cmd,
  input wire logic key_cmd,
  input wire logic [MEAS_W-1:0] meas_cmd,
  // signals into the engine
  output logic [NUM_SIG-1:0] sig_in,
  output logic back_key,
  output logic [MEAS_W-1:0] meas_in
);
  // relay inputs launch one clock after the command, as an input stage would
  always_ff @(posedge pclk) begin
    sig_in <= sig_cmd;
    back_key <= key_cmd;
    meas_in <= meas_cmd;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the relay logic engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rlg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, back_key, cycle_done, key_cmd, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sig_in, meas_in, sig_cmd, meas_cmd;
  logic [RES_W-1:0] logic_out;
  logic [1:0] ls [5] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
  logic sd [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic rdm [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  int errors, comparisons, pulses;
  // engine with a short logic cycle, relay side model beside it
  rlg_logic_engine #(.TICK_CNT(8)) rlg_logic_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sig_in(sig_in), .back_key(back_key), .meas_in(meas_in), .logic_out(logic_out),
    .cycle_done(cycle_done));
  rlg_relay_side rlg_relay_side_i (.pclk(pclk), .sig_cmd(sig_cmd), .key_cmd(key_cmd), .meas_cmd(meas_cmd),
    .sig_in(sig_in), .back_key(back_key), .meas_in(meas_in));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drive(input logic [15:0] v, input logic k, input logic [15:0] m);
    @(posedge pclk);
    sig_cmd <= v;
    key_cmd <= k;
    meas_cmd <= m;
  endtask
  // wait for k evaluations, counting edge pulses seen on the results
  task automatic cyc(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (cycle_done !== 1'b1 && n < 100);
      if (n >= 100) errors++;
      @(posedge pclk);
      #1;
      if (logic_out[9] === 1'b1) pulses++;
    end
  endtask
  task automatic step(input logic [15:0] v);
    drive(v, 1'b0, 16'h0000);
    pulses = 0;
    cyc(3);
  endtask
  function automatic logic cmp_exp(input int op, input int m);
    case (op)
      0: return m == 100;
      1: return m != 100;
      2: return m < 100;
      3: return m > 100;
      4: return m <= 100;
      default: return m >= 100;
    endcase
  endfunction
  // watchdog
  initial begin
    #500000;
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sig_cmd, key_cmd, meas_cmd} = '0;
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CAPACITY, 32'h0);
    check("capacity", rd, 32'h0100_0300);
    apb(1'b0, REG_CNT_TRIG, 32'h0);
    check("trigger", rd, 32'h0000_0001);
    apb(1'b0, 8'h38, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    // stop the cycle strobe, read the run bit back, then restart it
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check("run_off", rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    check("run_on", rd, 32'h1);
    apb(1'b1, REG_NOT_SEL, 32'h0);
    for (int a = 1; a < 5; a++) apb(1'b1, 8'(4 * a), 32'h3);
    // gates over both inputs
    for (int i = 0; i < 4; i++) begin
      step(16'(i));
      check("not", logic_out[RES_NOT], 32'(!i[0]));
      check("and", logic_out[RES_AND], 32'(i[0] & i[1]));
      check("or", logic_out[RES_OR], 32'(i[0] | i[1]));
      check("xor", logic_out[RES_XOR], 32'(i[0] ^ i[1]));
      check("nor", logic_out[RES_NOR], 32'(!(i[0] | i[1])));
    end
    // latches through set, hold, both, hold, clear
    apb(1'b1, REG_LATCH_SEL, 32'h0302_0302);
    for (int j = 0; j < 5; j++) begin
      step({12'h000, ls[j], 2'b00});
      check("set_dom", logic_out[5], 32'(sd[j]));
      check("rst_dom", logic_out[6], 32'(rdm[j]));
    end
    // counter, flip-flop and edge share node 4
    apb(1'b1, REG_SEQ_SEL, 32'h0504_0406);
    apb(1'b1, REG_EDGE_SEL, 32'h0008_0704);
    apb(1'b1, REG_CNT_TRIG, 32'h2);
    step(16'h0040);
    step(16'h0050);
    apb(1'b0, REG_CNT_VAL, 32'h0);
    check("count1", rd, 32'h1);
    check("cnt_out1", logic_out[8], 32'h0);
    check("ff1", logic_out[7], 32'h1);
    check("edge_rise_pol0", 32'(pulses), 32'h0);
    step(16'h0000);
    check("ff_hold", logic_out[7], 32'h1);
    check("edge_fall_pol0", 32'(pulses), 32'h1);
    step(16'h0090);
    apb(1'b0, REG_CNT_VAL, 32'h0);
    check("count2", rd, 32'h2);
    check("cnt_out2", logic_out[8], 32'h1);
    check("ff0", logic_out[7], 32'h0);
    check("edge_rise_pol1", 32'(pulses), 32'h1);
    step(16'h0020);
    apb(1'b0, REG_CNT_VAL, 32'h0);
    check("count_clr", rd, 32'h0);
    check("cnt_out_clr", logic_out[8], 32'h0);
    // panel latch: set, hold, key clears, input wins over key
    step(16'h0100);
    step(16'h0000);
    check("panel_hold", logic_out[10], 32'h1);
    drive(16'h0000, 1'b1, 16'h0000);
    cyc(2);
    check("panel_clear", logic_out[10], 32'h0);
    drive(16'h0100, 1'b1, 16'h0000);
    cyc(3);
    check("panel_win", logic_out[10], 32'h1);
    // comparator, every operator below and at the value
    for (int j = 0; j < 12; j++) begin
      apb(1'b1, REG_CMP_CFG, (32'(j / 2) << 16) | 32'h64);
      drive(16'h0000, 1'b0, j[0] ? 16'd50 : 16'd100);
      cyc(2);
      check("cmp", logic_out[11], 32'(cmp_exp(j / 2, j[0] ? 50 : 100)));
    end
    // delay 0: 10 ms rise on node 0, no fall delay
    apb(1'b1, 8'h40, 32'h0000_000A);
    apb(1'b0, 8'h40, 32'h0);
    check("dly_cfg", rd, 32'h0000_000A);
    step(16'h0000);
    drive(16'h0001, 1'b0, 16'h0000);
    cyc(2);
    check("dly_early", logic_out[RES_DLY], 32'h0);
    cyc(2);
    check("dly_rise", logic_out[RES_DLY], 32'h1);
    drive(16'h0000, 1'b0, 16'h0000);
    cyc(2);
    check("dly_fall", logic_out[RES_DLY], 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
